/* dv/accrued_flag_store.sv */
// Purpose: Status register stand-in holding the accrued flags
// Assumes: Written on every status write pulse of the unit
// Notes: Feeds stored flags back as the accrued input
`timescale 1ns/1ps
`default_nettype none
module accrued_flag_store (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic fsr_we,
	input wire logic [4:0] aexc,
	output logic [4:0] aexc_in
);
	logic [4:0] aexc_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aexc_q <= 5'h00;
		end else if (fsr_we) begin
			aexc_q <= aexc;
		end
	end
	// Cleared while reset is low so the input is known at time zero
	assign aexc_in = rst_n ? aexc_q : 5'h00;
endmodule
`default_nettype wire

/* dv/fma_unit_props.sv */
// Purpose: Port-level properties of the multiply-add unit
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the unit after the module
`timescale 1ns/1ps
`default_nettype none
module fma_unit_props (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic issue_valid,
	input wire logic [31:0] instr,
	input wire logic [63:0] src1,
	input wire logic [63:0] src2,
	input wire logic [63:0] src3,
	input wire logic fpu_enable,
	input wire logic [4:0] aexc_in,
	input wire logic done,
	input wire logic trap_valid,
	input wire fma_pkg::trap_kind_t trap_kind,
	input wire logic rd_we,
	input wire logic [63:0] rd_data,
	input wire logic fsr_we,
	input wire logic [4:0] cexc,
	input wire logic [4:0] aexc,
	input wire logic impl_opcode_perf_counter_inc
);
	logic [127:0] mac_q;
	logic hi_q;
	// Reference integer sum, one cycle behind the issue
	always_ff @(posedge sys_clk) begin
		mac_q <= {64'h0, src1} * {64'h0, src2} + {64'h0, src3};
		hi_q <= instr[7];
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_take;
		ce && issue_valid && instr[31:30] == 2'h2 && instr[24:19] == 6'h37;
	endsequence
	sequence s_int_ok;
		s_take ##0 (instr[6:5] == 2'h0 && !instr[8] && fpu_enable);
	endsequence
	property p_answer; s_take |=> done; endproperty
	a_answer: assert property (p_answer) else $error("no done after issue");
	property p_idle;
		ce && !(issue_valid && instr[31:30] == 2'h2 && instr[24:19] == 6'h37) |=> !done;
	endproperty
	a_idle: assert property (p_idle) else $error("done without issue");
	property p_quad;
		s_take ##0 instr[6:5] == 2'h3 |=> trap_kind == fma_pkg::TRAP_ILLEGAL && !fsr_we;
	endproperty
	a_quad: assert property (p_quad) else $error("size 3 not illegal");
	property p_int_var;
		s_take ##0 (instr[6:5] == 2'h0 && instr[8]) |=> trap_kind == fma_pkg::TRAP_ILLEGAL;
	endproperty
	a_int_var: assert property (p_int_var) else $error("bad integer form taken");
	property p_off;
		s_take ##0 (instr[6:5] != 2'h3 && !(instr[6:5] == 2'h0 && instr[8]) && !fpu_enable)
			|=> trap_kind == fma_pkg::TRAP_FLOAT_UNIT_OFF && !rd_we;
	endproperty
	a_off: assert property (p_off) else $error("unit off not trapped");
	property p_int_data;
		s_int_ok |=> rd_we && rd_data == (hi_q ? mac_q[127:64] : mac_q[63:0]);
	endproperty
	a_int_data: assert property (p_int_data) else $error("integer result wrong");
	property p_int_quiet;
		s_take ##0 instr[6:5] == 2'h0 |=> !fsr_we && !impl_opcode_perf_counter_inc;
	endproperty
	a_int_quiet: assert property (p_int_quiet) else $error("integer touched status");
	property p_no_trap_write; rd_we |-> !trap_valid && done; endproperty
	a_no_trap_write: assert property (p_no_trap_write) else $error("write with trap");
	property p_accrue;
		fsr_we && !trap_valid && $past(ce) |-> aexc == (cexc | $past(aexc_in));
	endproperty
	a_accrue: assert property (p_accrue) else $error("accrued not merged");
	property p_keep; fsr_we && trap_valid |-> aexc == $past(aexc_in); endproperty
	a_keep: assert property (p_keep) else $error("accrued changed on trap");
endmodule
bind fused_multiply_add_unit fma_unit_props fma_unit_props_i (
	.sys_clk, .rst_n, .ce, .issue_valid, .instr, .src1, .src2, .src3, .fpu_enable,
	.aexc_in, .done, .trap_valid, .trap_kind, .rd_we, .rd_data, .fsr_we, .cexc, .aexc,
	.impl_opcode_perf_counter_inc
);
`default_nettype wire

/* dv/fused_multiply_add_unit_tb_top.sv */
// Purpose: Self-checking bench for the multiply-add unit
// Assumes: Table rows run with clock enable high, nonstandard mode off, nearest rounding
// Notes: Reset, then table rows, then refusal, back-to-back and mid-run reset cases
`timescale 1ns/1ps
`default_nettype none
module fused_multiply_add_unit_tb_top;
	localparam fma_pkg::trap_kind_t tn = fma_pkg::TRAP_NONE;
	localparam fma_pkg::trap_kind_t ti = fma_pkg::TRAP_ILLEGAL;
	localparam fma_pkg::trap_kind_t tf = fma_pkg::TRAP_FLOAT_UNIT_OFF;
	localparam fma_pkg::trap_kind_t te = fma_pkg::TRAP_IEEE_FLOAT;
	localparam fma_pkg::trap_kind_t tu = fma_pkg::TRAP_UNFINISHED;
	localparam logic [63:0] c1 = 64'h3FF0000000000000;
	localparam logic [63:0] c2 = 64'h4000000000000000;
	localparam logic [63:0] c3 = 64'h4008000000000000;
	localparam logic [63:0] cinf = 64'h7FF0000000000000;
	localparam logic [63:0] cq = 64'h3FF0000002000000;
	typedef struct packed {
		logic [1:0] sz, vr;
		logic fen;
		logic [4:0] ten;
		logic [63:0] a, b, c;
		fma_pkg::trap_kind_t tk;
		logic [63:0] res;
		logic [4:0] cx;
	} row_t;
	logic sys_clk, rst_n, ce, issue_valid, fpu_enable, nonstandard_mode;
	logic [31:0] instr;
	logic [63:0] src1, src2, src3, rd_data;
	logic [1:0] round_mode;
	logic [4:0] trap_enable, aexc_in, rd_idx, cexc, aexc;
	logic done, trap_valid, rd_we, fsr_we, perf;
	fma_pkg::trap_kind_t trap_kind;
	int comparisons = 0;
	int miscompares = 0;
	row_t rows [21] = '{
		'{2'h2, 2'h0, 1'h1, 5'h00, c2, c3, c1, tn, 64'h401C000000000000, 5'h00},
		'{2'h2, 2'h1, 1'h1, 5'h00, c2, c3, c1, tn, 64'h4014000000000000, 5'h00},
		'{2'h2, 2'h2, 1'h1, 5'h00, c2, c3, c1, tn, 64'hC014000000000000, 5'h00},
		'{2'h2, 2'h3, 1'h1, 5'h00, c2, c3, c1, tn, 64'hC01C000000000000, 5'h00},
		'{2'h1, 2'h3, 1'h1, 5'h00, 64'h40000000, 64'h40400000, 64'h3F800000, tn,
			64'hC0E00000, 5'h00},
		'{2'h0, 2'h0, 1'h1, 5'h00, 64'hFFFFFFFFFFFFFFFF, 64'h2, 64'h3, tn, 64'h1, 5'h00},
		'{2'h0, 2'h1, 1'h1, 5'h00, 64'hFFFFFFFFFFFFFFFF, 64'h2, 64'h3, tn, 64'h2, 5'h00},
		'{2'h0, 2'h2, 1'h1, 5'h00, c1, c1, c1, ti, 64'h0, 5'h00},
		'{2'h0, 2'h3, 1'h1, 5'h00, c1, c1, c1, ti, 64'h0, 5'h00},
		'{2'h0, 2'h0, 1'h0, 5'h00, c1, c1, c1, tf, 64'h0, 5'h00},
		'{2'h3, 2'h0, 1'h0, 5'h00, c1, c1, c1, ti, 64'h0, 5'h00},
		'{2'h2, 2'h0, 1'h0, 5'h00, c1, c1, c1, tf, 64'h0, 5'h00},
		'{2'h2, 2'h1, 1'h1, 5'h00, cq, cq, c1, tn, 64'h3E50000001000000, 5'h00},
		'{2'h2, 2'h3, 1'h1, 5'h00, 64'h7FF8000000000005, c1, c1, tn,
			64'h7FF8000000000005, 5'h00},
		'{2'h2, 2'h2, 1'h1, 5'h00, c1, 64'hFFF8000000000005, c1, tn,
			64'hFFF8000000000005, 5'h00},
		'{2'h2, 2'h0, 1'h1, 5'h00, cinf, 64'h0, c1, tn, 64'h7FFFFFFFFFFFFFFF, 5'h10},
		'{2'h2, 2'h0, 1'h1, 5'h10, cinf, 64'h0, c1, te, 64'h0, 5'h10},
		'{2'h2, 2'h0, 1'h1, 5'h08, 64'h7FEFFFFFFFFFFFFF, c2, 64'h0, te, 64'h0, 5'h08},
		'{2'h2, 2'h0, 1'h1, 5'h00, 64'h7FEFFFFFFFFFFFFF, c2, 64'h0, tn, cinf, 5'h09},
		'{2'h2, 2'h0, 1'h1, 5'h00, c1, c1, 64'h3C30000000000000, tn, c1, 5'h01},
		'{2'h2, 2'h0, 1'h1, 5'h00, 64'h1, c1, c1, tu, 64'h0, 5'h00}
	};
	fused_multiply_add_unit fused_multiply_add_unit_i (
		.sys_clk, .rst_n, .ce, .issue_valid, .instr, .src1, .src2, .src3, .fpu_enable,
		.nonstandard_mode, .round_mode, .trap_enable, .aexc_in, .done, .trap_valid,
		.trap_kind, .rd_we, .rd_idx, .rd_data, .fsr_we, .cexc, .aexc,
		.impl_opcode_perf_counter_inc(perf)
	);
	accrued_flag_store accrued_flag_store_i (.sys_clk, .rst_n, .fsr_we, .aexc, .aexc_in);
	// Free-running 4 ns clock
	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_trap(input fma_pkg::trap_kind_t got, input fma_pkg::trap_kind_t exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t ns: trap kind %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Drives one row as an instruction; destination index is the row number
	task automatic put(input int i, input logic [5:0] op3);
		instr <= {2'h2, 5'(i), op3, 10'h000, rows[i].vr, rows[i].sz, 5'h00};
		src1 <= rows[i].a;
		src2 <= rows[i].b;
		src3 <= rows[i].c;
		fpu_enable <= rows[i].fen;
		trap_enable <= rows[i].ten;
		issue_valid <= 1'h1;
	endtask
	task automatic check(input int i);
		row_t r;
		logic w;
		r = rows[i];
		w = r.sz != 2'h0 && (r.tk == tn || r.tk == te);
		chk(64'(done), 64'h1);
		chk_trap(trap_kind, r.tk);
		chk(64'(trap_valid), 64'(r.tk != tn));
		chk(64'(rd_we), 64'(r.tk == tn));
		if (r.tk == tn) begin
			chk(rd_data, r.res);
			chk(64'(rd_idx), 64'(i));
		end
		chk(64'(fsr_we), 64'(w));
		if (w) begin
			chk(64'(cexc), 64'(r.cx));
		end
		chk(64'(perf), 64'(r.sz != 2'h0 && r.tk != ti && r.tk != tf));
	endtask
	task automatic run(input int i);
		@(posedge sys_clk);
		put(i, 6'h37);
		@(posedge sys_clk);
		issue_valid <= 1'h0;
		#1 check(i);
	endtask
	// Main sequence: reset, table, then refusal and back-to-back issue
	initial begin
		rst_n = 1'h0;
		ce = 1'h1;
		issue_valid = 1'h0;
		instr = 32'h0;
		src1 = 64'h0;
		src2 = 64'h0;
		src3 = 64'h0;
		fpu_enable = 1'h0;
		nonstandard_mode = 1'h0;
		round_mode = 2'h0;
		trap_enable = 5'h00;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'h1;
		#1 chk(64'(done | rd_we | fsr_we), 64'h0);
		chk_trap(trap_kind, tn);
		for (int i = 0; i < 21; i++) begin
			run(i);
		end
		@(posedge sys_clk);
		put(0, 6'h36);
		@(posedge sys_clk);
		issue_valid <= 1'h0;
		#1 chk(64'(done), 64'h0);
		@(posedge sys_clk);
		put(6, 6'h37);
		@(posedge sys_clk);
		put(16, 6'h37);
		#1 check(6);
		@(posedge sys_clk);
		issue_valid <= 1'h0;
		#1 check(16);
		// Nonstandard mode: flushed denormal source merges inexact, then traps on it
		@(posedge sys_clk);
		nonstandard_mode <= 1'h1;
		put(20, 6'h37);
		@(posedge sys_clk);
		trap_enable <= 5'h01;
		#1 chk_trap(trap_kind, tn);
		chk(rd_data, c1);
		chk(64'(cexc), 64'h01);
		@(posedge sys_clk);
		issue_valid <= 1'h0;
		#1 chk_trap(trap_kind, te);
		chk(64'(cexc), 64'h01);
		chk(64'(rd_we), 64'h0);
		// Round toward plus infinity lifts an inexact sum by one unit
		@(posedge sys_clk);
		nonstandard_mode <= 1'h0;
		round_mode <= 2'h2;
		put(19, 6'h37);
		@(posedge sys_clk);
		issue_valid <= 1'h0;
		#1 chk(rd_data, 64'h3FF0000000000001);
		chk(64'(cexc), 64'h01);
		// Clock enable low freezes the answer pulses
		@(posedge sys_clk);
		round_mode <= 2'h0;
		put(0, 6'h37);
		@(posedge sys_clk);
		issue_valid <= 1'h0;
		ce <= 1'h0;
		@(posedge sys_clk);
		ce <= 1'h1;
		#1 chk(64'(done & rd_we), 64'h1);
		chk(rd_data, rows[0].res);
		@(posedge sys_clk);
		#1 chk(64'(done | rd_we), 64'h0);
		// Reset in mid-run drops a pending issue and clears every output
		@(posedge sys_clk);
		put(5, 6'h37);
		rst_n <= 1'h0;
		@(posedge sys_clk);
		rst_n <= 1'h1;
		issue_valid <= 1'h0;
		#1 chk(64'(done | rd_we | fsr_we | trap_valid), 64'h0);
		chk(rd_data, 64'h0);
		chk(64'(cexc | aexc), 64'h0);
		run(5);
		stop_test;
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (3000) @(posedge sys_clk);
		miscompares++;
		$display("[ERR] %0t ns: watchdog expired", $time);
		stop_test;
	end
endmodule
`default_nettype wire

/* hw/fma_defines.svh */
// Purpose: Field positions, encodings, flag positions and reset values of the multiply-add unit
// Assumes: Included by bare name from every design file that needs it
// Notes: Exponent figures are signed 16-bit values
`ifndef FMA_DEFINES_SVH
`define FMA_DEFINES_SVH

// Instruction word fields
`define FMA_OP_HI 31
`define FMA_OP_LO 30
`define FMA_OP_VAL 2'h2
`define FMA_OP3_HI 24
`define FMA_OP3_LO 19
`define FMA_OP3_VAL 6'h37
`define FMA_RD_HI 29
`define FMA_RD_LO 25
`define FMA_VAR_HI 8
`define FMA_VAR_LO 7
`define FMA_SIZE_HI 6
`define FMA_SIZE_LO 5

// Size and variation encodings
`define SIZE_INT 2'h0
`define SIZE_SGL 2'h1
`define SIZE_DBL 2'h2
`define SIZE_QUAD 2'h3
`define VAR_NEG_BIT 1
`define VAR_SUB_BIT 0

// Exception flag positions and rounding modes
`define FLG_NV 4
`define FLG_OF 3
`define FLG_UF 2
`define FLG_DZ 1
`define FLG_NX 0
`define RM_NEAR 2'h0
`define RM_ZERO 2'h1
`define RM_PLUS 2'h2
`define RM_MINUS 2'h3

// Precision figures
`define SGL_PREC 6'h18
`define DBL_PREC 6'h35
`define SGL_BIAS 16'sh007F
`define DBL_BIAS 16'sh03FF
`define SGL_QMASK 64'h0000000000400000
`define DBL_QMASK 64'h0008000000000000
`define SGL_DEF_NAN 64'h000000007FFFFFFF
`define DBL_DEF_NAN 64'h7FFFFFFFFFFFFFFF

// Alignment window figures
`define WIN_TOP 16'sh00A3
`define WIN_LIMIT 16'sh00A4
`define ADD_BASE 16'sh0036
`define COLLAPSE_D 16'sh0038
`define COLLAPSE_SH 16'sh006E
`define PROD_ORG 16'sh006A
`define COLL_ORG 16'sh00A2
`define ADD_LOST_MAX 16'sh0035

// Reset values
`define FLAGS_RST 5'h00
`define RESULT_RST 64'h0000000000000000
`define RD_RST 5'h00

`endif

/* hw/fma_int_mac.sv */
// Purpose: Unsigned 64 by 64 multiply plus 64-bit addend, low or high half out
// Assumes: Operands are plain unsigned integers
// Notes: The 128-bit sum cannot overflow
`timescale 1ns/1ps
`default_nettype none
module fma_int_mac (
	input wire logic [63:0] a,
	input wire logic [63:0] b,
	input wire logic [63:0] c,
	input wire logic high,
	output logic [63:0] res
);
	logic [127:0] full;

	// Exact product plus addend, half select
	always_comb begin
		full = ({64'h0, a} * {64'h0, b}) + {64'h0, c};
		res = high ? full[127:64] : full[63:0];
	end
endmodule
`default_nettype wire

/* hw/fma_pkg.sv */
// Purpose: Types shared by the multiply-add unit and its bench
// Assumes: Nothing beyond the defines header
// Notes: Trap kinds are reported one per issued instruction
`default_nettype none
package fma_pkg;
	typedef enum logic [2:0] {
		TRAP_NONE = 3'h0,
		TRAP_FLOAT_UNIT_OFF = 3'h1,
		TRAP_ILLEGAL = 3'h3,
		TRAP_IEEE_FLOAT = 3'h2,
		TRAP_UNFINISHED = 3'h6
	} trap_kind_t;
	typedef logic [4:0] flags_t;
endpackage
`default_nettype wire

/* hw/fma_unpack.sv */
// Purpose: Splits a single or double operand into sign, unbiased exponent and significand
// Assumes: Single operands sit in the low 32 bits
// Notes: Single fractions are left aligned onto the double fraction
`include "fma_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fma_unpack (
	input wire logic [63:0] raw,
	input wire logic dbl,
	output logic sign,
	output logic signed [15:0] exp_u,
	output logic [52:0] man,
	output logic is_zero,
	output logic is_inf,
	output logic is_nan,
	output logic is_snan,
	output logic is_den
);
	logic [10:0] ef;
	logic [10:0] ef_max;
	logic [51:0] fr;
	logic signed [15:0] bias;

	// Field split per precision
	always_comb begin
		if (dbl) begin
			sign = raw[63];
			ef = raw[62:52];
			fr = raw[51:0];
			ef_max = 11'h7FF;
			bias = `DBL_BIAS;
		end else begin
			sign = raw[31];
			ef = {3'h0, raw[30:23]};
			fr = {raw[22:0], 29'h0};
			ef_max = 11'h0FF;
			bias = `SGL_BIAS;
		end
	end

	// Classification and significand with hidden bit
	always_comb begin
		is_zero = (ef == 11'h000) && (fr == 52'h0);
		is_den = (ef == 11'h000) && (fr != 52'h0);
		is_inf = (ef == ef_max) && (fr == 52'h0);
		is_nan = (ef == ef_max) && (fr != 52'h0);
		is_snan = is_nan && !fr[51];
		man = {ef != 11'h000, fr};
		exp_u = ((ef == 11'h000) ? 16'sh0001 : $signed({5'h00, ef})) - bias;
	end
endmodule
`default_nettype wire

/* hw/fused_multiply_add_unit.sv */
// Purpose: Fused multiply-add execution unit, floating-point and unsigned integer forms
// Assumes: Operands and status arrive from same-clock issue logic; one cycle latency
// Notes: Results and status updates appear the cycle after an accepted issue
// Summary of operation
// - Decode family from op3 110111, variation bits 8..7, size bits 6..5.
// - Size 01 single, 10 double, 00 integer; 11 traps illegal.
// - Variation 00 gives product plus third source.
// - Variation 01 gives product minus third source.
// - Variation 11 gives negated product minus third source.
// - Variation 10 gives negated product plus third source.
// - Exact product, one single rounding after the add.
// - Negated forms pass a NaN source out with its sign untouched.
// - Multiply invalid or flushed denormal trap aborts, sets current, keeps accrued.
// - Add stage acts only without a multiply-stage trap.
// - Add-stage trap records only trapping flags, accrued kept.
// - No trap: current gets multiply and add flags, accrued ORs current in.
// - Unfinished trap checks sources one two, then source three and result.
// - Current flags merge multiply invalid, add flags, and multiply inexact under nonstandard.
// - Float unit off traps float forms; size 11 illegal before that.
// - Integer variation 00 writes low 64 bits of product plus addend.
// - Integer variation 01 writes high 64 bits of product plus addend.
// - Integer forms never touch the float status flags.
// - Integer forms never pulse the opcode-space performance counter.
// - Integer variations 10, 11 illegal; valid ones trap when float unit off.
`include "fma_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fused_multiply_add_unit (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic issue_valid,
	input wire logic [31:0] instr,
	input wire logic [63:0] src1,
	input wire logic [63:0] src2,
	input wire logic [63:0] src3,
	input wire logic fpu_enable,
	input wire logic nonstandard_mode,
	input wire logic [1:0] round_mode,
	input wire logic [4:0] trap_enable,
	input wire logic [4:0] aexc_in,
	output logic done,
	output logic trap_valid,
	output fma_pkg::trap_kind_t trap_kind,
	output logic rd_we,
	output logic [4:0] rd_idx,
	output logic [63:0] rd_data,
	output logic fsr_we,
	output logic [4:0] cexc,
	output logic [4:0] aexc,
	output logic impl_opcode_perf_counter_inc
);
	logic [1:0] op_size;
	logic [1:0] op_var;
	logic is_fam, fire, dbl, int_form, ns;
	logic s1, s2, s3, z1, z2, z3, i1, i2, i3, n1, n2, n3, q1, q2, q3, d1, d2, d3;
	logic signed [15:0] e1, e2, e3;
	logic [52:0] m1, m2, m3, mf1, mf2, mf3;
	logic signed [15:0] bias, emin, emax, ep, dd, sa, nsh, org, e_msb, ek, ef, lsbi, nl;
	logic [5:0] prec;
	logic [105:0] mp;
	logic collapse, prod_sign, add_sign, eff_sub, astk, rsign;
	logic [163:0] pwin, awin, mag;
	logic [7:0] lz;
	logic [53:0] sig, sig_r, sig_n;
	logic rnd, stk, inc, tiny_nz, ovf, nx_fin, mag_nz;
	logic signed [15:0] be;
	logic [63:0] fin_res, fp_res, int_res, qmask, wmask;
	logic mul_inv, add_inv, prod_inf, special, unf, mul_trap, add_trap;
	fma_pkg::flags_t mul_fl, add_fl, cexc_nt;
	fma_pkg::trap_kind_t kind_d;

	// Count of leading zeros across the sum window
	function automatic logic [7:0] lead_zeros(input logic [163:0] v);
		logic [7:0] n;
		logic found;
		n = 8'h00;
		found = 1'b0;
		for (int i = 163; i >= 0; i--) begin
			if (!found) begin
				if (v[i]) found = 1'b1;
				else n = n + 8'h01;
			end
		end
		return n;
	endfunction

	assign is_fam = (instr[`FMA_OP_HI:`FMA_OP_LO] == `FMA_OP_VAL) &&
		(instr[`FMA_OP3_HI:`FMA_OP3_LO] == `FMA_OP3_VAL);
	assign op_var = instr[`FMA_VAR_HI:`FMA_VAR_LO];
	assign op_size = instr[`FMA_SIZE_HI:`FMA_SIZE_LO];
	assign fire = ce && issue_valid && is_fam;
	assign dbl = (op_size == `SIZE_DBL);
	assign int_form = (op_size == `SIZE_INT);
	assign ns = nonstandard_mode;

	fma_unpack u_op1 (.raw(src1), .dbl(dbl), .sign(s1), .exp_u(e1), .man(m1), .is_zero(z1),
		.is_inf(i1), .is_nan(n1), .is_snan(q1), .is_den(d1));
	fma_unpack u_op2 (.raw(src2), .dbl(dbl), .sign(s2), .exp_u(e2), .man(m2), .is_zero(z2),
		.is_inf(i2), .is_nan(n2), .is_snan(q2), .is_den(d2));
	fma_unpack u_op3 (.raw(src3), .dbl(dbl), .sign(s3), .exp_u(e3), .man(m3), .is_zero(z3),
		.is_inf(i3), .is_nan(n3), .is_snan(q3), .is_den(d3));

	fma_int_mac u_int (.a(src1), .b(src2), .c(src3), .high(op_var[0]), .res(int_res));

	// Precision figures and sign of each term
	always_comb begin
		bias = dbl ? `DBL_BIAS : `SGL_BIAS;
		prec = dbl ? `DBL_PREC : `SGL_PREC;
		emin = 16'sh0001 - bias;
		emax = bias;
		prod_sign = s1 ^ s2 ^ op_var[`VAR_NEG_BIT];
		add_sign = s3 ^ op_var[`VAR_SUB_BIT];
		eff_sub = prod_sign ^ add_sign;
		// Denormals become zero under nonstandard mode
		mf1 = (ns && d1) ? 53'h0 : m1;
		mf2 = (ns && d2) ? 53'h0 : m2;
		mf3 = (ns && d3) ? 53'h0 : m3;
	end

	// exact product aligned with the addend, no rounding here
	always_comb begin
		mp = mf1 * mf2;
		ep = e1 + e2;
		dd = e3 - ep;
		collapse = dd > `COLLAPSE_D;
		sa = collapse ? `COLLAPSE_SH : dd + `ADD_BASE;
		nsh = -sa;
		org = collapse ? e3 - `COLL_ORG : ep - `PROD_ORG;
		// A product far below the addend only matters as a sticky bit
		pwin = collapse ? {163'h0, |mp} : {56'h0, mp, 2'h0};
		if (sa >= 16'sh0000) begin
			awin = {111'h0, mf3} << sa[7:0];
			astk = 1'b0;
		end else if (sa > -`ADD_LOST_MAX) begin
			awin = {111'h0, mf3} >> nsh[5:0];
			astk = |(mf3 & ((53'h1 << nsh[5:0]) - 53'h1));
		end else begin
			awin = 164'h0;
			astk = |mf3;
		end
		awin = awin | {163'h0, astk};
		if (!eff_sub) begin
			mag = pwin + awin;
			rsign = prod_sign;
		end else if (pwin >= awin) begin
			mag = pwin - awin;
			rsign = prod_sign;
		end else begin
			mag = awin - pwin;
			rsign = add_sign;
		end
		mag_nz = (mag != 164'h0);
		// Exact zero takes the sign of like terms, else depends on rounding
		if (!mag_nz) rsign = eff_sub ? (round_mode == `RM_MINUS) : prod_sign;
	end

	always_comb begin
		lz = lead_zeros(mag);
		e_msb = org + `WIN_TOP - $signed({8'h00, lz});
		tiny_nz = mag_nz && (e_msb < emin);
		ek = (e_msb < emin) ? emin : e_msb;
		lsbi = ek - ($signed({10'h000, prec}) - 16'sh0001) - org;
		nl = -lsbi;
		if (lsbi <= 16'sh0000) begin
			sig = 54'(mag << nl[5:0]);
			rnd = 1'b0;
			stk = 1'b0;
		end else if (lsbi > `WIN_LIMIT) begin
			sig = 54'h0;
			rnd = 1'b0;
			stk = mag_nz;
		end else begin
			sig = 54'(mag >> lsbi[7:0]);
			rnd = mag[lsbi[7:0] - 8'h01];
			stk = |(mag & ((164'h1 << (lsbi[7:0] - 8'h01)) - 164'h1));
		end
		case (round_mode)
			`RM_NEAR: inc = rnd && (stk || sig[0]);
			`RM_ZERO: inc = 1'b0;
			`RM_PLUS: inc = !rsign && (rnd || stk);
			default: inc = rsign && (rnd || stk);
		endcase
		sig_r = sig + {53'h0, inc};
		sig_n = sig_r[prec] ? (sig_r >> 1) : sig_r;
		ef = sig_r[prec] ? ek + 16'sh0001 : ek;
		ovf = mag_nz && (ef > emax);
		nx_fin = rnd || stk || ovf;
		be = sig_n[prec - 6'h01] ? ef + bias : 16'sh0000;
		if (ovf && ((round_mode == `RM_NEAR) || (round_mode == `RM_PLUS && !rsign) ||
				(round_mode == `RM_MINUS && rsign)))
			fin_res = dbl ? {rsign, 11'h7FF, 52'h0} : {32'h0, rsign, 8'hFF, 23'h0};
		else if (ovf)
			fin_res = dbl ? {rsign, 11'h7FE, {52{1'b1}}} : {32'h0, rsign, 8'hFE, {23{1'b1}}};
		else if (ns && tiny_nz)
			fin_res = dbl ? {rsign, 63'h0} : {32'h0, rsign, 31'h0};
		else
			fin_res = dbl ? {rsign, be[10:0], sig_n[51:0]} : {32'h0, rsign, be[7:0], sig_n[22:0]};
	end

	// Special operands and result select
	always_comb begin
		mul_inv = q1 || q2 || (i1 && z2) || (z1 && i2);
		prod_inf = (i1 || i2) && !mul_inv && !n1 && !n2;
		add_inv = q3 || (prod_inf && i3 && eff_sub && !n3);
		special = n1 || n2 || n3 || mul_inv || prod_inf || i3;
		qmask = dbl ? `DBL_QMASK : `SGL_QMASK;
		wmask = dbl ? 64'hFFFFFFFFFFFFFFFF : 64'h00000000FFFFFFFF;
		// NaN source passes with its own sign
		if (n1) fp_res = (src1 & wmask) | qmask;
		else if (n2) fp_res = (src2 & wmask) | qmask;
		else if (n3) fp_res = (src3 & wmask) | qmask;
		else if (mul_inv || add_inv) fp_res = dbl ? `DBL_DEF_NAN : `SGL_DEF_NAN;
		else if (prod_inf || i3) begin
			fp_res = dbl ? {prod_inf ? prod_sign : add_sign, 11'h7FF, 52'h0} :
				{32'h0, prod_inf ? prod_sign : add_sign, 8'hFF, 23'h0};
		end else fp_res = fin_res;
	end

	always_comb begin
		mul_fl = `FLAGS_RST;
		mul_fl[`FLG_NV] = mul_inv;
		mul_fl[`FLG_NX] = ns && !special && (d1 || d2);
		add_fl = `FLAGS_RST;
		// add flags only from the finite or special add path
		add_fl[`FLG_NV] = special && add_inv;
		add_fl[`FLG_OF] = !special && ovf;
		add_fl[`FLG_UF] = !special && ns && tiny_nz;
		add_fl[`FLG_NX] = !special && (nx_fin || (ns && (tiny_nz || d3)));
		cexc_nt = mul_fl | add_fl;
		mul_trap = |(mul_fl & trap_enable);
		unf = !ns && !special && (d1 || d2 || d3 || tiny_nz);
		add_trap = |(add_fl & trap_enable);
	end

	// trap priority, illegal encodings before the unit-off check
	always_comb begin
		if (op_size == `SIZE_QUAD) kind_d = fma_pkg::TRAP_ILLEGAL;
		else if (int_form && op_var[`VAR_NEG_BIT]) kind_d = fma_pkg::TRAP_ILLEGAL;
		else if (!fpu_enable) kind_d = fma_pkg::TRAP_FLOAT_UNIT_OFF;
		else if (int_form) kind_d = fma_pkg::TRAP_NONE;
		else if (mul_trap) kind_d = fma_pkg::TRAP_IEEE_FLOAT;
		else if (unf) kind_d = fma_pkg::TRAP_UNFINISHED;
		else if (add_trap) kind_d = fma_pkg::TRAP_IEEE_FLOAT;
		else kind_d = fma_pkg::TRAP_NONE;
	end

	// Completion and trap report
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			done <= 1'b0;
			trap_valid <= 1'b0;
			trap_kind <= fma_pkg::TRAP_NONE;
		end else if (ce) begin
			done <= fire;
			trap_valid <= fire && (kind_d != fma_pkg::TRAP_NONE);
			if (fire) trap_kind <= kind_d;
		end
	end

	// destination write only on a clean finish
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_we <= 1'b0;
			rd_idx <= `RD_RST;
			rd_data <= `RESULT_RST;
		end else if (ce) begin
			rd_we <= fire && (kind_d == fma_pkg::TRAP_NONE);
			if (fire && (kind_d == fma_pkg::TRAP_NONE)) begin
				rd_idx <= instr[`FMA_RD_HI:`FMA_RD_LO];
				rd_data <= int_form ? int_res : fp_res;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fsr_we <= 1'b0;
			cexc <= `FLAGS_RST;
			aexc <= `FLAGS_RST;
		end else if (ce) begin
			fsr_we <= 1'b0;
			if (fire && !int_form) begin
				if (kind_d == fma_pkg::TRAP_NONE) begin
					fsr_we <= 1'b1;
					cexc <= cexc_nt;
					aexc <= aexc_in | cexc_nt;
				end else if (kind_d == fma_pkg::TRAP_IEEE_FLOAT) begin
					fsr_we <= 1'b1;
					cexc <= mul_trap ? mul_fl : (add_fl & trap_enable);
					aexc <= aexc_in;
				end
			end
		end
	end

	// counter pulse for float forms that pass decode and the unit-off check
	always_ff @(posedge sys_clk) begin
		if (!rst_n) impl_opcode_perf_counter_inc <= 1'b0;
		else if (ce) impl_opcode_perf_counter_inc <= fire && !int_form &&
			(kind_d != fma_pkg::TRAP_ILLEGAL) && (kind_d != fma_pkg::TRAP_FLOAT_UNIT_OFF);
	end
endmodule
`default_nettype wire
